// ===== core/dmc_timing_cfg.sv
// timing and configuration register block of the dynamic memory controller, with its counters
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module dmc_timing_cfg (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clkEn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // controller state and scheduler events
   input wire logic inConfigState,
   input wire logic inLowPowerState,
   input wire logic writeIssued,
   input wire logic pdExitIssued,
   input wire logic srExitIssued,
   input wire logic srEntryIssued,
   input wire logic refreshIssued,
   input wire logic initDone,
   input wire logic ckeRun,
   input wire logic dqmRun,
   input wire logic casHalfIn,
   input wire logic rdValidIn,
   input wire logic readReq,
   input wire logic [3:0] readMasterId,
   input wire logic [7:0] chipAddrHi,
   // results
   output logic readAllowed,
   output logic cmdAllowed,
   output logic srEntryBusy,
   output logic rdValidOut,
   output logic [2:0] memType,
   output logic [1:0] memWidth,
   output logic syncClocks,
   output logic busFasterFlag,
   output logic ckeOut,
   output logic dqmOut,
   output logic casHalfOut,
   output logic refreshRequest,
   output logic [2:0] outstandingRefs,
   output logic qosApply,
   output logic [7:0] qosMax,
   output logic qosMin,
   output logic chipSelected,
   output logic orgBankRowCol
);
   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [dmc_pkg::WTR_W-1:0] wtrDelay;
   logic [dmc_pkg::TIME_W-1:0] pdExitTime;
   logic [dmc_pkg::TIME_W-1:0] srExitTime;
   logic [dmc_pkg::TIME_W-1:0] srEntryTime;
   logic [dmc_pkg::CFGB_W-1:0] cfgB;
   logic [dmc_pkg::CFGC_W-1:0] cfgC;
   logic [dmc_pkg::QOS_W-1:0] qosCfg [dmc_pkg::QOS_COUNT];
   logic [dmc_pkg::CHIP_W-1:0] chipCfg;

   // ---------------------------------------------------------------
   // ahb-lite slave
   // ---------------------------------------------------------------
   logic accessOk;
   logic addrPhase;
   logic wrPend;
   logic [dmc_pkg::ADDR_W-1:0] wrAddr;
   logic [31:0] next_rdata;
   logic wrNow;
   logic [dmc_pkg::QOS_IDX_W-1:0] wrQosIdx;
   logic wrQosHit;

   // registers only answer in the configuration or low-power state
   assign accessOk = inConfigState || inLowPowerState;
   assign addrPhase = hsel && hready && htrans[1];
   // zero wait states; every transfer, mapped or not, ends OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // address phase captured for the data phase that follows
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wrPend <= 1'b0;
         wrAddr <= '0;
      end else if (clkEn) begin
         wrPend <= addrPhase && hwrite;
         if (addrPhase) begin
            wrAddr <= haddr[dmc_pkg::ADDR_W-1:0];
         end
      end
   end

   // write takes effect in the data phase, and only while access is open
   assign wrNow = clkEn && wrPend && accessOk;
   assign wrQosHit = wrAddr >= dmc_pkg::OFF_QOS_FIRST && wrAddr <= dmc_pkg::OFF_QOS_LAST && wrAddr[1:0] == 2'h0;
   assign wrQosIdx = wrAddr[dmc_pkg::QOS_IDX_W+1:2];

   // read mux; locked-out or unmapped reads return zero
   always_comb begin
      logic [dmc_pkg::ADDR_W-1:0] a;
      a = haddr[dmc_pkg::ADDR_W-1:0];
      next_rdata = 32'h0000_0000;
      if (accessOk) begin
         if (a == dmc_pkg::OFF_WTR) begin
            next_rdata[dmc_pkg::WTR_W-1:0] = wtrDelay;
         end else if (a == dmc_pkg::OFF_TXP) begin
            next_rdata[dmc_pkg::TIME_W-1:0] = pdExitTime;
         end else if (a == dmc_pkg::OFF_TXSR) begin
            next_rdata[dmc_pkg::TIME_W-1:0] = srExitTime;
         end else if (a == dmc_pkg::OFF_TESR) begin
            next_rdata[dmc_pkg::TIME_W-1:0] = srEntryTime;
         end else if (a == dmc_pkg::OFF_CFGB) begin
            next_rdata[dmc_pkg::CFGB_W-1:0] = cfgB;
         end else if (a == dmc_pkg::OFF_CFGC) begin
            next_rdata[dmc_pkg::CFGC_W-1:0] = cfgC;
         end else if (a >= dmc_pkg::OFF_QOS_FIRST && a <= dmc_pkg::OFF_QOS_LAST && a[1:0] == 2'h0) begin
            next_rdata[dmc_pkg::QOS_W-1:0] = qosCfg[a[dmc_pkg::QOS_IDX_W+1:2]];
         end else if (a == dmc_pkg::OFF_CHIP) begin
            next_rdata[dmc_pkg::CHIP_W-1:0] = chipCfg;
         end
      end
   end

   // read data registered at the address phase, stands in the data phase
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         hrdata <= 32'h0000_0000;
      end else if (clkEn && addrPhase && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // timing and global configuration registers
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wtrDelay <= dmc_pkg::RST_WTR;
         pdExitTime <= dmc_pkg::RST_TXP;
         srExitTime <= dmc_pkg::RST_TXSR;
         srEntryTime <= dmc_pkg::RST_TESR;
         cfgB <= dmc_pkg::RST_CFGB;
         cfgC <= dmc_pkg::RST_CFGC;
         chipCfg <= dmc_pkg::RST_CHIP;
      end else if (wrNow) begin
         if (wrAddr == dmc_pkg::OFF_WTR) begin
            wtrDelay <= hwdata[dmc_pkg::WTR_W-1:0];
         end
         if (wrAddr == dmc_pkg::OFF_TXP) begin
            pdExitTime <= hwdata[dmc_pkg::TIME_W-1:0];
         end
         if (wrAddr == dmc_pkg::OFF_TXSR) begin
            srExitTime <= hwdata[dmc_pkg::TIME_W-1:0];
         end
         if (wrAddr == dmc_pkg::OFF_TESR) begin
            srEntryTime <= hwdata[dmc_pkg::TIME_W-1:0];
         end
         if (wrAddr == dmc_pkg::OFF_CFGB) begin
            cfgB <= hwdata[dmc_pkg::CFGB_W-1:0];
         end
         if (wrAddr == dmc_pkg::OFF_CFGC) begin
            cfgC <= hwdata[dmc_pkg::CFGC_W-1:0];
         end
         if (wrAddr == dmc_pkg::OFF_CHIP) begin
            chipCfg <= hwdata[dmc_pkg::CHIP_W-1:0];
         end
      end
   end

   // one configuration word per master slot
   for (genvar g = 0; g < dmc_pkg::QOS_COUNT; g++) begin : gQos
      always_ff @(posedge mclk) begin
         if (!reset_n) begin
            qosCfg[g] <= dmc_pkg::RST_QOS;
         end else if (wrNow && wrQosHit && wrQosIdx == dmc_pkg::QOS_IDX_W'(g)) begin
            qosCfg[g] <= hwdata[dmc_pkg::QOS_W-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // decoded configuration
   // ---------------------------------------------------------------
   logic [dmc_pkg::RDDLY_W-1:0] readDelay;
   logic [dmc_pkg::PRESC_W-1:0] prescale;
   logic [dmc_pkg::MAXREF_W-1:0] maxRefs;

   assign readDelay = cfgB[dmc_pkg::RDDLY_LSB +: dmc_pkg::RDDLY_W];
   assign memType = cfgB[dmc_pkg::MTYPE_LSB +: dmc_pkg::MTYPE_W];
   assign memWidth = cfgB[dmc_pkg::MWID_LSB +: dmc_pkg::MWID_W];
   // clock relationship flags are software's duty; passed on to the crossing logic
   assign busFasterFlag = cfgB[dmc_pkg::BUSFAST_BIT];
   assign syncClocks = cfgB[dmc_pkg::SYNC_BIT];
   assign prescale = cfgC[dmc_pkg::PRESC_LSB +: dmc_pkg::PRESC_W];
   assign maxRefs = cfgC[dmc_pkg::MAXREF_LSB +: dmc_pkg::MAXREF_W];
   assign orgBankRowCol = chipCfg[dmc_pkg::ORG_BIT];
   // no half-cycle CAS offset on SDR or LPDDR parts
   assign casHalfOut = (memType == dmc_pkg::MT_SDR || memType == dmc_pkg::MT_LPDDR) ? 1'b0 : casHalfIn;

   // ---------------------------------------------------------------
   // command spacing counters
   // ---------------------------------------------------------------
   logic [dmc_pkg::WTR_W-1:0] wtrCount;
   logic [dmc_pkg::TIME_W-1:0] exitCount;
   logic [dmc_pkg::TIME_W-1:0] srEntryCount;

   // write to read hold-off
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wtrCount <= '0;
      end else if (clkEn) begin
         if (writeIssued) begin
            wtrCount <= wtrDelay;
         end else if (wtrCount != '0) begin
            wtrCount <= wtrCount - 1'b1;
         end
      end
   end
   assign readAllowed = (wtrCount == '0);

   // exit waits share one counter since only one exit can be in flight
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         exitCount <= '0;
      end else if (clkEn) begin
         if (pdExitIssued) begin
            exitCount <= pdExitTime;
         end else if (srExitIssued) begin
            exitCount <= srExitTime;
         end else if (exitCount != '0) begin
            exitCount <= exitCount - 1'b1;
         end
      end
   end
   assign cmdAllowed = (exitCount == '0);

   // self-refresh entry command time
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         srEntryCount <= '0;
      end else if (clkEn) begin
         if (srEntryIssued) begin
            srEntryCount <= srEntryTime;
         end else if (srEntryCount != '0) begin
            srEntryCount <= srEntryCount - 1'b1;
         end
      end
   end
   assign srEntryBusy = (srEntryCount != '0);

   // ---------------------------------------------------------------
   // pad read latency
   // ---------------------------------------------------------------
   localparam int PIPE_D = 3;
   logic [PIPE_D-1:0] rdPipe;

   // a short shift line; the tap picks the programmed extra latency
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rdPipe <= '0;
      end else if (clkEn) begin
         rdPipe <= {rdPipe[PIPE_D-2:0], rdValidIn};
      end
   end
   assign rdValidOut = (readDelay == '0) ? rdValidIn : rdPipe[readDelay - 1'b1];

   // ---------------------------------------------------------------
   // cke and dqm levels
   // ---------------------------------------------------------------
   // until initialisation ends the pins show the programmed idle levels
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ckeOut <= 1'b0;
         dqmOut <= 1'b0;
      end else if (clkEn) begin
         ckeOut <= initDone ? ckeRun : cfgB[dmc_pkg::CKEINIT_BIT];
         dqmOut <= initDone ? dqmRun : cfgB[dmc_pkg::DQMINIT_BIT];
      end
   end

   // ---------------------------------------------------------------
   // refresh pacing
   // ---------------------------------------------------------------
   logic [dmc_pkg::PRESC_W-1:0] prescCount;
   logic refreshTick;
   logic incRef;
   logic decRef;

   // prescale of zero stops the prescaler, so no refreshes are queued
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         prescCount <= '0;
      end else if (clkEn) begin
         if (prescCount == '0) begin
            prescCount <= prescale;
         end else begin
            prescCount <= prescCount - 1'b1;
         end
      end
   end
   assign refreshTick = (prescale != '0) && (prescCount == '0);
   assign incRef = refreshTick && (outstandingRefs < maxRefs);
   assign decRef = refreshIssued && (outstandingRefs != '0);

   // outstanding refreshes, capped at the programmed maximum
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         outstandingRefs <= '0;
      end else if (clkEn) begin
         if (incRef && !decRef) begin
            outstandingRefs <= outstandingRefs + 1'b1;
         end else if (decRef && !incRef) begin
            outstandingRefs <= outstandingRefs - 1'b1;
         end
      end
   end
   assign refreshRequest = (outstandingRefs != '0);

   // ---------------------------------------------------------------
   // qos and chip select lookups
   // ---------------------------------------------------------------
   logic [dmc_pkg::QOS_W-1:0] qosSel;
   logic [dmc_pkg::CSEL_W-1:0] csMatch;
   logic [dmc_pkg::CSEL_W-1:0] csMask;

   assign qosSel = qosCfg[readMasterId];
   assign csMatch = chipCfg[dmc_pkg::MATCH_LSB +: dmc_pkg::CSEL_W];
   assign csMask = chipCfg[dmc_pkg::MASK_LSB +: dmc_pkg::CSEL_W];

   // registered so the scheduler sees stable values; costs one cycle
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         qosApply <= 1'b0;
         qosMax <= '0;
         qosMin <= 1'b0;
         chipSelected <= 1'b0;
      end else if (clkEn) begin
         qosApply <= readReq && qosSel[dmc_pkg::QEN_BIT];
         qosMax <= qosSel[dmc_pkg::QMAX_LSB +: dmc_pkg::QMAX_W];
         qosMin <= qosSel[dmc_pkg::QMIN_BIT];
         chipSelected <= ((chipAddrHi ^ csMatch) & csMask) == '0;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence sWrData;
      clkEn && wrPend;
   endsequence
   sequence sLocked;
      !inConfigState && !inLowPowerState;
   endsequence

   a_wtr_holdoff: assert property (clkEn && writeIssued |=> wtrCount == $past(wtrDelay))
      else $error("write to read count not loaded");
   a_pd_exit_wait: assert property (clkEn && pdExitIssued && pdExitTime != '0 |=> !cmdAllowed)
      else $error("command allowed during power-down exit");
   a_sr_exit_wait: assert property (clkEn && srExitIssued && !pdExitIssued |=> exitCount == $past(srExitTime))
      else $error("self-refresh exit count wrong");
   a_sr_entry_time: assert property (clkEn && srEntryIssued |=> srEntryCount == $past(srEntryTime))
      else $error("self-refresh entry count not loaded");
   a_read_latency: assert property (clkEn && readDelay == 2'h2 && rdValidIn ##1 clkEn |=> rdValidOut || readDelay != 2'h2)
      else $error("read latency of two not applied");
   a_cas_forced: assert property (memType == dmc_pkg::MT_SDR || memType == dmc_pkg::MT_LPDDR |-> !casHalfOut)
      else $error("half cycle cas not forced off");
   a_locked_write: assert property (sWrData and sLocked |=> $stable(cfgB) && $stable(wtrDelay) && $stable(chipCfg))
      else $error("write accepted outside open state");
   a_refresh_cap: assert property (outstandingRefs <= maxRefs || $past(maxRefs) != maxRefs || outstandingRefs != $past(outstandingRefs) + 3'h1)
      else $error("outstanding refreshes passed limit");
   a_chip_match: assert property (clkEn && (chipAddrHi & csMask) == (csMatch & csMask) |=> chipSelected)
      else $error("matching address not selected");
   a_cke_init: assert property (clkEn && !initDone |=> ckeOut == $past(cfgB[dmc_pkg::CKEINIT_BIT]))
      else $error("cke not at init level");
endmodule

// ===== include/dmc_pkg.sv
// constants and field layout for the memory controller timing and configuration registers
package dmc_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFF_WTR = 12'h03c;
   localparam logic [ADDR_W-1:0] OFF_TXP = 12'h040;
   localparam logic [ADDR_W-1:0] OFF_TXSR = 12'h044;
   localparam logic [ADDR_W-1:0] OFF_TESR = 12'h048;
   localparam logic [ADDR_W-1:0] OFF_CFGB = 12'h04c;
   localparam logic [ADDR_W-1:0] OFF_CFGC = 12'h050;
   localparam logic [ADDR_W-1:0] OFF_QOS_FIRST = 12'h100;
   localparam logic [ADDR_W-1:0] OFF_QOS_LAST = 12'h13c;
   localparam logic [ADDR_W-1:0] OFF_CHIP = 12'h200;
   localparam int QOS_COUNT = 16;
   localparam int QOS_IDX_W = 4;
   // ---------------------------------------------------------------
   // field widths and positions
   // ---------------------------------------------------------------
   localparam int WTR_W = 3;
   localparam int TIME_W = 8;
   localparam int CFGB_W = 11;
   localparam int CFGC_W = 12;
   localparam int QOS_W = 10;
   localparam int CHIP_W = 17;
   localparam int RDDLY_LSB = 9;
   localparam int RDDLY_W = 2;
   localparam int MTYPE_LSB = 6;
   localparam int MTYPE_W = 3;
   localparam int MWID_LSB = 4;
   localparam int MWID_W = 2;
   localparam int CKEINIT_BIT = 3;
   localparam int DQMINIT_BIT = 2;
   localparam int BUSFAST_BIT = 1;
   localparam int SYNC_BIT = 0;
   localparam int PRESC_LSB = 3;
   localparam int PRESC_W = 9;
   localparam int MAXREF_LSB = 0;
   localparam int MAXREF_W = 3;
   localparam int QMAX_LSB = 2;
   localparam int QMAX_W = 8;
   localparam int QMIN_BIT = 1;
   localparam int QEN_BIT = 0;
   localparam int ORG_BIT = 16;
   localparam int MATCH_LSB = 8;
   localparam int MASK_LSB = 0;
   localparam int CSEL_W = 8;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [WTR_W-1:0] RST_WTR = 3'h2;
   localparam logic [TIME_W-1:0] RST_TXP = 8'h01;
   localparam logic [TIME_W-1:0] RST_TXSR = 8'h0a;
   localparam logic [TIME_W-1:0] RST_TESR = 8'h14;
   localparam logic [CFGB_W-1:0] RST_CFGB = 11'h000;
   localparam logic [CFGC_W-1:0] RST_CFGC = 12'h000;
   localparam logic [QOS_W-1:0] RST_QOS = 10'h000;
   localparam logic [CHIP_W-1:0] RST_CHIP = 17'h0ff00;
   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   localparam logic [MTYPE_W-1:0] MT_SDR = 3'h0;
   localparam logic [MTYPE_W-1:0] MT_DDR = 3'h1;
   localparam logic [MTYPE_W-1:0] MT_EDRAM = 3'h2;
   localparam logic [MTYPE_W-1:0] MT_LPDDR = 3'h3;
   localparam logic [MWID_W-1:0] MW_16 = 2'h0;
   localparam logic [MWID_W-1:0] MW_32 = 2'h1;
   localparam logic [MWID_W-1:0] MW_64 = 2'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ===== tb/dmc_mem_model.sv
// behavioural model of the external memory returning the read data strobe after a fixed pad delay
`timescale 1ns/1ps
module dmc_mem_model #(
   parameter int LAT = 3
) (
   input wire logic mclk,
   input wire logic readCmd,
   output logic rdValidIn
);
   logic [LAT-1:0] pipe = '0;
   // data strobe comes back LAT cycles after the read command, one cycle wide
   always @(posedge mclk) begin
      pipe <= {pipe[LAT-2:0], readCmd};
   end
   assign rdValidIn = pipe[LAT-1];
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the timing and configuration register block
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0;
   logic resetN = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, hready, readCmd = 1'b0, hresp, clkEn = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = dmc_pkg::HSIZE_WORD;
   logic inConfigState = 1'b1, inLowPowerState = 1'b0, initDone = 1'b0, casHalfIn = 1'b1;
   logic writeIssued = 1'b0, pdExitIssued = 1'b0, srExitIssued = 1'b0, srEntryIssued = 1'b0;
   logic refreshIssued = 1'b0, readReq = 1'b0, rdValidIn;
   logic [3:0] readMasterId = 4'h0;
   logic [7:0] chipAddrHi = 8'h00;
   logic readAllowed, cmdAllowed, srEntryBusy, rdValidOut, syncClocks, busFasterFlag, ckeOut, dqmOut;
   logic casHalfOut, refreshRequest, qosApply, qosMin, chipSelected, orgBankRowCol;
   logic [2:0] memType, outstandingRefs;
   logic [1:0] memWidth;
   logic [7:0] qosMax;
   int num_errors = 0, checked = 0, cyc = 0;
   logic [11:0] offs[11] = '{dmc_pkg::OFF_WTR, dmc_pkg::OFF_TXP, dmc_pkg::OFF_TXSR, dmc_pkg::OFF_TESR,
      dmc_pkg::OFF_CFGB, dmc_pkg::OFF_CFGC, dmc_pkg::OFF_QOS_FIRST, dmc_pkg::OFF_QOS_LAST,
      dmc_pkg::OFF_CHIP, 12'h300, 12'h054};
   logic [31:0] rst[11] = '{32'h2, 32'h1, 32'ha, 32'h14, 32'h0, 32'h0, 32'h0, 32'h0, 32'hff00, 32'h0, 32'h0};

   always #25 mclk = ~mclk;

   dmc_timing_cfg i_dut (.mclk(mclk), .reset_n(resetN), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .inConfigState(inConfigState),
      .inLowPowerState(inLowPowerState), .writeIssued(writeIssued), .pdExitIssued(pdExitIssued),
      .srExitIssued(srExitIssued), .srEntryIssued(srEntryIssued), .refreshIssued(refreshIssued),
      .initDone(initDone), .ckeRun(1'b0), .dqmRun(1'b0), .casHalfIn(casHalfIn), .rdValidIn(rdValidIn),
      .readReq(readReq), .readMasterId(readMasterId), .chipAddrHi(chipAddrHi), .readAllowed(readAllowed),
      .cmdAllowed(cmdAllowed), .srEntryBusy(srEntryBusy), .rdValidOut(rdValidOut), .memType(memType),
      .memWidth(memWidth), .syncClocks(syncClocks), .busFasterFlag(busFasterFlag), .ckeOut(ckeOut),
      .dqmOut(dqmOut), .casHalfOut(casHalfOut), .refreshRequest(refreshRequest),
      .outstandingRefs(outstandingRefs), .qosApply(qosApply), .qosMax(qosMax), .qosMin(qosMin),
      .chipSelected(chipSelected), .orgBankRowCol(orgBankRowCol));

   dmc_mem_model #(.LAT(3)) i_mem (.mclk(mclk), .readCmd(readCmd), .rdValidIn(rdValidIn));

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("errors %0d, comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // a hang anywhere ends the run as a failure
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // ahb-lite master: address phase held until hready, then data phase
   // ---------------------------------------------------------------
   task automatic ahb(input logic [11:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      haddr <= {20'h0, a};
      hwrite <= wr;
      htrans <= dmc_pkg::HTRANS_NONSEQ;
      hsel <= 1'b1;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(a, 1'b1, d, q);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ahb(a, 1'b0, 32'h0, q);
      check(q, exp);
      check(hresp, 1'b0);
   endtask

   // a scheduler event, then the length of the hold-off it causes
   function automatic logic held(input int k);
      return (k == 0) ? !readAllowed : (k == 3) ? srEntryBusy : !cmdAllowed;
   endfunction

   task automatic ev(input int k, input int n);
      int c;
      c = 0;
      @(posedge mclk);
      {srEntryIssued, srExitIssued, pdExitIssued, writeIssued} <= 4'h1 << k;
      @(posedge mclk);
      {srEntryIssued, srExitIssued, pdExitIssued, writeIssued} <= 4'h0;
      @(negedge mclk);
      while (held(k) === 1'b1 && c < 300) begin
         c++;
         @(negedge mclk);
      end
      check(c, n);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge mclk);
      resetN <= 1'b1;
      for (int i = 0; i < 11; i++) rdchk(offs[i], rst[i]);
      // a low clock enable must swallow a scheduler event
      clkEn <= 1'b0;
      writeIssued <= 1'b1;
      @(posedge mclk);
      writeIssued <= 1'b0;
      clkEn <= 1'b1;
      @(negedge mclk);
      check(readAllowed, 1'b1);
      // locked out of config and low-power: reads give 0, writes are dropped
      inConfigState <= 1'b0;
      wr(dmc_pkg::OFF_WTR, 32'h5);
      rdchk(dmc_pkg::OFF_WTR, 32'h0);
      inLowPowerState <= 1'b1;
      rdchk(dmc_pkg::OFF_WTR, 32'h2);
      inLowPowerState <= 1'b0;
      inConfigState <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(offs[k], k + 3);
         ev(k, k + 3);
      end
      // every memory type and width code, with the half-cycle cas override
      for (int t = 0; t < 4; t++) begin
         wr(dmc_pkg::OFF_CFGB, (t << 6) | ((t == 3 ? 2 : t) << 4));
         @(negedge mclk);
         check(memType, t);
         check(memWidth, t == 3 ? 2 : t);
         check(casHalfOut, t == 1 || t == 2);
      end
      wr(dmc_pkg::OFF_CFGB, 32'h40a);
      repeat (2) @(negedge mclk);
      check({ckeOut, dqmOut, busFasterFlag, syncClocks}, 4'ha);
      rdchk(dmc_pkg::OFF_CFGB, 32'h40a);
      // pad latency of two adds two cycles to the returned strobe
      @(posedge mclk);
      readCmd <= 1'b1;
      @(posedge mclk);
      readCmd <= 1'b0;
      do @(negedge mclk); while (rdValidIn !== 1'b1);
      begin : lat_wait
         int n;
         n = 0;
         while (rdValidOut !== 1'b1 && n < 8) begin
            n++;
            @(negedge mclk);
         end
         check(n, 2);
      end
      // prescaler fills the refresh queue up to the cap, an issued refresh drains one
      wr(dmc_pkg::OFF_CFGC, 32'h0a);
      repeat (12) @(negedge mclk);
      check({refreshRequest, outstandingRefs}, 4'ha);
      wr(dmc_pkg::OFF_CFGC, 32'h02);
      @(posedge mclk);
      refreshIssued <= 1'b1;
      @(posedge mclk);
      refreshIssued <= 1'b0;
      @(negedge mclk);
      check(outstandingRefs, 3'h1);
      // chip match with only the upper nibble compared
      wr(dmc_pkg::OFF_CHIP, 32'h1a5f0);
      chipAddrHi <= 8'ha7;
      repeat (2) @(negedge mclk);
      check({orgBankRowCol, chipSelected}, 2'h3);
      chipAddrHi <= 8'h57;
      repeat (2) @(negedge mclk);
      check(chipSelected, 1'b0);
      // qos of the last slot applied only to that master's reads
      wr(dmc_pkg::OFF_QOS_LAST, 32'hf3);
      readMasterId <= 4'hf;
      readReq <= 1'b1;
      repeat (2) @(negedge mclk);
      check({qosApply, qosMin, qosMax}, 10'h33c);
      readMasterId <= 4'h0;
      repeat (2) @(negedge mclk);
      check(qosApply, 1'b0);
      wrap_up();
   end
endmodule
